// *** dv/core_model.sv ***
// Behavioural processor core that runs instructions, vectors and returns
`timescale 1ns/10ps
module core_model (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic irq_req_i,
	input wire logic slow_i,
	input wire logic ret_go_i,
	output logic instr_done_o,
	output logic vector_ack_o,
	output logic return_done_o
);
	logic [1:0] wait_cnt;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			instr_done_o <= 1'b0;
			vector_ack_o <= 1'b0;
			return_done_o <= 1'b0;
			wait_cnt <= 2'h0;
		end else begin
			instr_done_o <= !irq_req_i && !instr_done_o && !ret_go_i;
			// long call, slow core stalls it
			vector_ack_o <= irq_req_i && !vector_ack_o && (!slow_i || wait_cnt == 2'h3);
			wait_cnt <= irq_req_i ? wait_cnt + 2'h1 : 2'h0;
			return_done_o <= ret_go_i;
		end
	end
endmodule

// *** dv/two_level_interrupt_control_assertions.sv ***
// Port timing checker for the interrupt controller
`timescale 1ns/10ps
module irq_ctrl_checker (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic instr_done_i,
	input wire logic vector_ack_i,
	input wire logic irq_req_o,
	input wire logic [15:0] vector_addr_o,
	input wire logic [3:0] vector_src_o,
	input wire logic [1:0] active_level_o
);
	// ****
	// Properties
	// ****
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data not idle");
	a_req_holds: assert property (irq_req_o && !vector_ack_i |=> irq_req_o)
		else $error("request dropped early");
	a_req_ack_drop: assert property (irq_req_o && vector_ack_i |=> !irq_req_o)
		else $error("request kept after ack");
	a_vector_map: assert property (irq_req_o |-> vector_addr_o == irq_ctrl_pkg::VECTOR_BASE
		+ irq_ctrl_pkg::VECTOR_STEP * {12'h000, vector_src_o})
		else $error("vector address wrong");
	a_req_after_done: assert property ($rose(irq_req_o) |-> $past(instr_done_i))
		else $error("request without finished instruction");
	a_ack_sets_level: assert property (irq_req_o && vector_ack_i |=> active_level_o != 2'h0)
		else $error("no active level after vector");
	a_src_in_range: assert property (irq_req_o |-> vector_src_o < 4'hE)
		else $error("source index out of range");
	a_no_high_preempt: assert property ($rose(irq_req_o) |-> !active_level_o[1])
		else $error("high routine preempted");
endmodule

bind two_level_interrupt_control irq_ctrl_checker i_chk (.*);

// *** dv/two_level_interrupt_control_bench.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module two_level_interrupt_control_bench;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [13:0] src_event_i = 14'h0000;
	logic [3:0] reg_addr_i = 4'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic next_multi_cycle_i = 1'b0;
	logic slow = 1'b0;
	logic ret_go = 1'b0;
	logic [7:0] reg_rdata_o;
	logic instr_done_i, vector_ack_i, return_done_i, irq_req_o;
	logic [15:0] vector_addr_o;
	logic [3:0] vector_src_o;
	logic [1:0] active_level_o;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	int s;
	int n;
	int mc_mode = 2;
	always #25 clock_i = ~clock_i;
	two_level_interrupt_control i_dut (.*);
	core_model i_core (.clock_i(clock_i), .rstn_i(rstn_i), .irq_req_i(irq_req_o),
		.slow_i(slow), .ret_go_i(ret_go), .instr_done_o(instr_done_i),
		.vector_ack_o(vector_ack_i), .return_done_o(return_done_i));
	// ****
	// Tasks
	// ****
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		@(negedge clock_i);
		chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
	endtask
	task automatic ev(input logic [13:0] m);
		@(posedge clock_i);
		src_event_i <= m;
		@(posedge clock_i);
		src_event_i <= 14'h0000;
	endtask
	task automatic en(input logic [13:0] m, input logic g);
		wr(irq_ctrl_pkg::OFF_IRQ_ENABLE, {g, m[6:0]});
		wr(irq_ctrl_pkg::OFF_EXT_ENABLE, {1'b0, m[13:7]});
	endtask
	task automatic clr(input logic [7:0] lo);
		wr(irq_ctrl_pkg::OFF_PEND_LO, lo);
		wr(irq_ctrl_pkg::OFF_PEND_HI, 8'h00);
	endtask
	task automatic quiet(input int k);
		repeat (k) begin
			@(negedge clock_i);
			chk("irq_req", 16'h0000, {15'h0000, irq_req_o});
		end
	endtask
	task automatic ret();
		@(posedge clock_i);
		ret_go <= 1'b1;
		@(posedge clock_i);
		ret_go <= 1'b0;
		@(negedge clock_i);
	endtask
	// Enable cleared in the very cycle an instruction ends with a fresh request
	task automatic race(input int mc);
		@(negedge clock_i);
		mc_mode = mc;
		n = 0;
		while (instr_done_i !== 1'b1 && n < 40) begin
			@(negedge clock_i);
			n++;
		end
		@(posedge clock_i);
		src_event_i <= 14'h0001;
		@(posedge clock_i);
		src_event_i <= 14'h0000;
		reg_wr_i <= 1'b1;
		reg_addr_i <= irq_ctrl_pkg::OFF_IRQ_ENABLE;
		reg_wdata_i <= 8'h00;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		@(negedge clock_i);
		mc_mode = 2;
	endtask
	function automatic logic [15:0] vec(input int i);
		return irq_ctrl_pkg::VECTOR_BASE + irq_ctrl_pkg::VECTOR_STEP * i[15:0];
	endfunction
	// Level is checked once the request has gone, when the ack has landed
	task automatic take(input int i, input logic [1:0] lvl);
		n = 0;
		while (irq_req_o !== 1'b1 && n < 40) begin
			@(negedge clock_i);
			n++;
		end
		chk("irq_req", 16'h0001, {15'h0000, irq_req_o});
		chk("src", i[15:0], {12'h000, vector_src_o});
		chk("addr", vec(i), vector_addr_o);
		while (irq_req_o === 1'b1 && n < 80) begin
			@(negedge clock_i);
			n++;
		end
		chk("level", {14'h0000, lvl}, {14'h0000, active_level_o});
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ****
	// Random core inputs and hang guard
	// ****
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		next_multi_cycle_i <= (mc_mode == 2) ? 1'($urandom % 2) : mc_mode[0];
		slow <= 1'($urandom % 2);
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(38));
		repeat (4) @(posedge clock_i);
		rstn_i <= 1'b1;
		rd(irq_ctrl_pkg::OFF_IRQ_ENABLE, irq_ctrl_pkg::ENABLE_RESET);
		rd(4'hF, 8'h00);
		en(14'h3FFF, 1'b0);
		ev(14'h0004);
		quiet(12);
		rd(irq_ctrl_pkg::OFF_PEND_LO, 8'h04);
		en(14'h0000, 1'b1);
		quiet(12);
		repeat (6) begin
			s = $urandom % 14;
			clr(8'h00);
			en(14'h0001 << s, 1'b1);
			ev(14'h0001 << s);
			take(s, 2'h1);
			clr(8'h00);
			ret();
			quiet(10);
		end
		en(14'h0228, 1'b1);
		wr(irq_ctrl_pkg::OFF_PRIO_HI, 8'h02);
		ev(14'h0028);
		take(3, 2'h1);
		ev(14'h0200);
		take(9, 2'h3);
		quiet(10);
		wr(irq_ctrl_pkg::OFF_PEND_HI, 8'h00);
		ret();
		quiet(10);
		clr(8'h20);
		ret();
		n = 0;
		s = 0;
		while (irq_req_o !== 1'b1 && s < 40) begin
			if (instr_done_i === 1'b1) n++;
			@(negedge clock_i);
			s++;
		end
		chk("reentry", 16'h0001, n[15:0]);
		take(5, 2'h1);
		clr(8'h00);
		ret();
		wr(irq_ctrl_pkg::OFF_AUTOCLR_LO, 8'h01);
		en(14'h0001, 1'b1);
		ev(14'h0001);
		take(0, 2'h1);
		rd(irq_ctrl_pkg::OFF_PEND_LO, 8'h00);
		ret();
		quiet(10);
		en(14'h0001, 1'b1);
		race(1);
		quiet(10);
		wr(irq_ctrl_pkg::OFF_IRQ_ENABLE, 8'h00);
		clr(8'h00);
		en(14'h0001, 1'b1);
		race(0);
		take(0, 2'h1);
		wr(irq_ctrl_pkg::OFF_IRQ_ENABLE, 8'h00);
		rd(irq_ctrl_pkg::OFF_IRQ_ENABLE, 8'h00);
		ret();
		quiet(10);
		tally_and_finish();
	end
endmodule

// *** verilog/irq_arbiter.sv ***
// Fixed order arbiter choosing the winning source and its level
`timescale 1ns/10ps
module irq_arbiter (
	input wire logic [13:0] req_i,
	input wire logic [13:0] prio_i,
	output logic valid_o,
	output logic high_o,
	output logic [3:0] idx_o
);
	logic [13:0] hi_req;

	assign hi_req = req_i & prio_i;

	// ****************************************************************
	// Selection
	// ****************************************************************
	// lowest index wins, high level first
	always_comb begin
		valid_o = 1'b0;
		high_o = 1'b0;
		idx_o = 4'h0;
		for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (req_i[i] && !valid_o) begin
				idx_o = i[3:0];
			end
		end
		for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				idx_o = i[3:0];
			end
		end
		valid_o = |req_i;
		if (|hi_req) begin
			high_o = 1'b1;
			for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
				if (hi_req[i]) begin
					idx_o = i[3:0];
				end
			end
		end
	end
endmodule

// *** verilog/irq_ctrl_pkg.sv ***
// Package with constants and types for the two level interrupt controller
package irq_ctrl_pkg;
	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_SRC = 14;
	localparam int SRC_IDX_W = 4;
	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 8;
	localparam int VECTOR_W = 16;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [3:0] OFF_IRQ_ENABLE = 4'h0;
	localparam logic [3:0] OFF_EXT_ENABLE = 4'h1;
	localparam logic [3:0] OFF_PEND_LO = 4'h2;
	localparam logic [3:0] OFF_PEND_HI = 4'h3;
	localparam logic [3:0] OFF_PRIO_LO = 4'h4;
	localparam logic [3:0] OFF_PRIO_HI = 4'h5;
	localparam logic [3:0] OFF_STATUS = 4'h6;
	localparam logic [3:0] OFF_AUTOCLR_LO = 4'h7;
	localparam logic [3:0] OFF_AUTOCLR_HI = 4'h8;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int GLOBAL_EN_BIT = 7;
	localparam int IE_SRC_BITS = 7;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [13:0] PRIO_RESET = 14'h0000;
	localparam logic [13:0] AUTOCLR_RESET = 14'h0000;
	localparam logic [15:0] VECTOR_BASE = 16'h0003;
	localparam logic [15:0] VECTOR_STEP = 16'h0008;

	typedef enum logic [1:0] {
		LVL_NONE,
		LVL_LOW,
		LVL_HIGH
	} level_e;
endpackage

// *** verilog/irq_pend_flag.sv ***
// One pending flag with hardware set, software and vector clear
`timescale 1ns/10ps
module irq_pend_flag (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic set_i,
	input wire logic sw_wr_i,
	input wire logic sw_val_i,
	input wire logic hw_clr_i,
	output logic flag_o
);
	logic flag;
	logic next_flag;

	// ****************************************************************
	// Flag logic
	// ****************************************************************
	always_comb begin
		next_flag = flag;
		if (sw_wr_i) begin
			next_flag = sw_val_i;
		end
		if (hw_clr_i) begin
			next_flag = 1'b0;
		end
		if (set_i) begin
			next_flag = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end

	assign flag_o = flag;
endmodule

// *** verilog/two_level_interrupt_control.sv ***
// Two level interrupt controller with pending flags, enables and vectoring
`timescale 1ns/10ps
module two_level_interrupt_control (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [13:0] src_event_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic instr_done_i,
	input wire logic next_multi_cycle_i,
	input wire logic vector_ack_i,
	input wire logic return_done_i,
	output logic irq_req_o,
	output logic [15:0] vector_addr_o,
	output logic [3:0] vector_src_o,
	output logic [1:0] active_level_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0] irq_enable_reg;
	logic [7:0] extended_irq_enable_reg;
	logic [13:0] prio;
	logic [13:0] autoclr;
	logic [7:0] next_irq_enable_reg;
	logic [7:0] next_extended_irq_enable_reg;
	logic [13:0] next_prio;
	logic [13:0] next_autoclr;
	logic [13:0] pend;
	logic [13:0] src_en;
	logic [13:0] req;
	logic [13:0] hw_clr;
	logic global_irq_enable;
	logic en_clearing;
	logic race_block;
	logic hold_req;
	logic next_hold_req;
	logic in_low;
	logic in_high;
	logic next_in_low;
	logic next_in_high;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic [15:0] vec;
	logic [15:0] next_vec;
	logic [3:0] vsrc;
	logic [3:0] next_vsrc;
	logic arb_valid;
	logic arb_high;
	logic [3:0] arb_idx;
	logic may_take;
	logic take;
	logic wr_pend_lo;
	logic wr_pend_hi;
	logic [13:0] pend_wval;

	// ****************************************************************
	// Source enables
	// ****************************************************************
	// global bit gates individual enables
	assign global_irq_enable = irq_enable_reg[irq_ctrl_pkg::GLOBAL_EN_BIT];
	assign src_en = {extended_irq_enable_reg[6:0], irq_enable_reg[6:0]};
	assign req = global_irq_enable ? (pend & src_en) : 14'h0000;

	// ****************************************************************
	// Pending flags
	// ****************************************************************
	assign wr_pend_lo = reg_wr_i && (reg_addr_i == irq_ctrl_pkg::OFF_PEND_LO);
	assign wr_pend_hi = reg_wr_i && (reg_addr_i == irq_ctrl_pkg::OFF_PEND_HI);
	assign pend_wval = {reg_wdata_i[5:0], reg_wdata_i};

	generate
		for (genvar g = 0; g < irq_ctrl_pkg::NUM_SRC; g++) begin : g_flag
			// hardware clear on vector when selected
			assign hw_clr[g] = vector_ack_i && (vsrc == 4'(g)) && autoclr[g];
			irq_pend_flag u_flag (
				.clock_i(clock_i),
				.rstn_i(rstn_i),
				.set_i(src_event_i[g]),
				.sw_wr_i(g < 8 ? wr_pend_lo : wr_pend_hi),
				.sw_val_i(pend_wval[g]),
				.hw_clr_i(hw_clr[g]),
				.flag_o(pend[g])
			);
		end
	endgenerate

	// ****************************************************************
	// Arbitration
	// ****************************************************************
	irq_arbiter u_arb (
		.req_i(req),
		.prio_i(prio),
		.valid_o(arb_valid),
		.high_o(arb_high),
		.idx_o(arb_idx)
	);

	assign may_take = arb_valid && !in_high && (!in_low || arb_high);

	always_comb begin
		en_clearing = 1'b0;
		if (reg_wr_i && (reg_addr_i == irq_ctrl_pkg::OFF_IRQ_ENABLE)) begin
			en_clearing = |(irq_enable_reg & ~reg_wdata_i);
		end
		if (reg_wr_i && (reg_addr_i == irq_ctrl_pkg::OFF_EXT_ENABLE)) begin
			en_clearing = |(extended_irq_enable_reg[6:0] & ~reg_wdata_i[6:0]);
		end
	end
	// Old enables still rule this boundary, so only a multi-cycle successor closes it
	assign race_block = en_clearing && next_multi_cycle_i;
	assign take = may_take && instr_done_i && !hold_req && !race_block && !return_done_i;

	// ****************************************************************
	// Registers and sequencing
	// ****************************************************************
	always_comb begin
		next_irq_enable_reg = irq_enable_reg;
		next_extended_irq_enable_reg = extended_irq_enable_reg;
		next_prio = prio;
		next_autoclr = autoclr;
		next_hold_req = hold_req;
		next_in_low = in_low;
		next_in_high = in_high;
		next_vec = vec;
		next_vsrc = vsrc;
		next_rdata = 8'h00;
		if (reg_wr_i) begin
			case (reg_addr_i)
				irq_ctrl_pkg::OFF_IRQ_ENABLE: begin
					next_irq_enable_reg = reg_wdata_i;
				end
				irq_ctrl_pkg::OFF_EXT_ENABLE: begin
					next_extended_irq_enable_reg = {1'b0, reg_wdata_i[6:0]};
				end
				irq_ctrl_pkg::OFF_PRIO_LO: next_prio[7:0] = reg_wdata_i;
				irq_ctrl_pkg::OFF_PRIO_HI: next_prio[13:8] = reg_wdata_i[5:0];
				irq_ctrl_pkg::OFF_AUTOCLR_LO: next_autoclr[7:0] = reg_wdata_i;
				irq_ctrl_pkg::OFF_AUTOCLR_HI: next_autoclr[13:8] = reg_wdata_i[5:0];
				default: begin
				end
			endcase
		end
		if (take) begin
			next_hold_req = 1'b1;
			next_vsrc = arb_idx;
			next_vec = irq_ctrl_pkg::VECTOR_BASE + 16'(arb_idx) * irq_ctrl_pkg::VECTOR_STEP;
		end
		if (vector_ack_i && hold_req) begin
			next_hold_req = 1'b0;
			if (prio[vsrc]) begin
				next_in_high = 1'b1;
			end else begin
				next_in_low = 1'b1;
			end
		end
		if (return_done_i) begin
			if (in_high) begin
				next_in_high = 1'b0;
			end else begin
				next_in_low = 1'b0;
			end
		end
		// enable reads show the stored register value
		if (reg_rd_i) begin
			case (reg_addr_i)
				irq_ctrl_pkg::OFF_IRQ_ENABLE: next_rdata = irq_enable_reg;
				irq_ctrl_pkg::OFF_EXT_ENABLE: next_rdata = extended_irq_enable_reg;
				irq_ctrl_pkg::OFF_PEND_LO: next_rdata = pend[7:0];
				irq_ctrl_pkg::OFF_PEND_HI: next_rdata = {2'b00, pend[13:8]};
				irq_ctrl_pkg::OFF_PRIO_LO: next_rdata = prio[7:0];
				irq_ctrl_pkg::OFF_PRIO_HI: next_rdata = {2'b00, prio[13:8]};
				irq_ctrl_pkg::OFF_STATUS: next_rdata = {hold_req, 3'b000, vsrc} | {5'h00, in_high, in_low, 1'b0} & 8'h06;
				irq_ctrl_pkg::OFF_AUTOCLR_LO: next_rdata = autoclr[7:0];
				irq_ctrl_pkg::OFF_AUTOCLR_HI: next_rdata = {2'b00, autoclr[13:8]};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_enable_reg <= irq_ctrl_pkg::ENABLE_RESET;
			extended_irq_enable_reg <= irq_ctrl_pkg::ENABLE_RESET;
			prio <= irq_ctrl_pkg::PRIO_RESET;
			autoclr <= irq_ctrl_pkg::AUTOCLR_RESET;
			hold_req <= 1'b0;
			in_low <= 1'b0;
			in_high <= 1'b0;
			rdata <= 8'h00;
			vec <= 16'h0000;
			vsrc <= 4'h0;
		end else begin
			irq_enable_reg <= next_irq_enable_reg;
			extended_irq_enable_reg <= next_extended_irq_enable_reg;
			prio <= next_prio;
			autoclr <= next_autoclr;
			hold_req <= next_hold_req;
			in_low <= next_in_low;
			in_high <= next_in_high;
			rdata <= next_rdata;
			vec <= next_vec;
			vsrc <= next_vsrc;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Request held until the core acknowledges the long call
	assign irq_req_o = hold_req;
	assign vector_addr_o = vec;
	assign vector_src_o = vsrc;
	assign active_level_o = {in_high, in_low};
	assign reg_rdata_o = rdata;
endmodule
